// >>> rtl/cpm_top.sv
// codec power management with its link register access
`default_nettype none
module cpm_top #(
  parameter int BITCLK_HALF_DIV = 4
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       powerup_strap_in,
  input  wire logic       bit_clk_in,
  output wire logic       bit_clk_out,
  output var  logic       bit_clk_oe_out,
  input  wire logic       ext_clk_sel_in,
  input  wire logic       sync_in,
  input  wire logic       sdata_out_in,
  output var  logic       sdata_in_out,
  input  wire logic       wake_event_in,
  output var  logic [15:0] block_en_out,
  output var  logic       sleep_out,
  output var  logic       standby_out,
  output var  logic       ref_string_on_out,
  output var  logic       unused_pins_held_out,
  output var  logic [1:0] bias_level_out,
  output var  logic       first_mic_input_ref_off_out,
  output var  logic       second_mic_input_ref_off_out,
  output var  logic       beep_input_ref_off_out,
  output var  logic       battery_measure_en_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_s1_ff;
  logic       rst_s2_ff;
  wire  logic rst_n = rst_s2_ff;
  logic [5:0] pin_s;
  wire  logic s_strap  = pin_s[0];
  wire  logic s_bclk   = pin_s[1];
  wire  logic s_extsel = pin_s[2];
  wire  logic s_sync   = pin_s[3];
  wire  logic s_sdo    = pin_s[4];
  wire  logic s_wake   = pin_s[5];

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  cpm_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .d_in       ({wake_event_in, sdata_out_in, sync_in,
                  ext_clk_sel_in, bit_clk_in, powerup_strap_in}),
    .q_out      (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] std_pd_ff;
  logic [15:0] ext_pd_ff;
  logic [15:0] afc_ff;
  logic [15:0] bias_ff;
  logic [15:0] beep_ff;
  logic [15:0] mic_ff;
  logic [15:0] rec_ff;
  logic        init_ff;
  cpm_pkg::cpm_link_e st_ff;
  cpm_pkg::cpm_link_e nxt_st;
  logic [7:0]  wake_cnt_ff;
  logic        sync_lvl_ff;
  logic [7:0]  cnt_ff;
  logic        frame_ok_ff;
  logic        sync_prev_ff;
  logic [19:0] shift_ff;
  logic [2:0]  tag_ff;
  logic        rw_ff;
  logic [6:0]  addr_ff;
  logic        rsp_pend_ff;
  logic        rsp_live_ff;
  logic [6:0]  rsp_addr_ff;
  logic [15:0] rsp_data_ff;

  ////////////////////////////////////////////////////////////////////////
  // bit clock

  wire logic bclk_rise;
  wire logic bclk_fall;
  wire logic link_up = (st_ff == cpm_pkg::ST_ACTIVE) &
                       ~std_pd_ff[cpm_pkg::STD_LINK_OFF];
  // the oscillator needs both clock-off bits clear
  wire logic osc_on  = ~ext_pd_ff[cpm_pkg::EXT_OSC_OFF] &
                       ~std_pd_ff[cpm_pkg::STD_CLK_OFF];
  wire logic run_clk = link_up & osc_on;  // see [RL22]

  cpm_bitclk #(
    .HALF_DIV (BITCLK_HALF_DIV)
  ) u_bitclk (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n),
    .run_in     (run_clk),
    .ext_sel_in (s_extsel),
    .ext_clk_in (s_bclk),
    .clk_out    (bit_clk_out),
    .rise_out   (bclk_rise),
    .fall_out   (bclk_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame receive: bits are taken on the falling bit clock edge

  wire logic       rx_fall  = bclk_fall & link_up;
  wire logic       sync_up  = s_sync & ~sync_prev_ff;
  wire logic [7:0] cur_b    = sync_up ? 8'h00 : 8'(cnt_ff + 8'h01);
  wire logic [19:0] sh_nxt  = {shift_ff[18:0], s_sdo};
  wire logic       at_tag   = rx_fall & frame_ok_ff &
                              (cur_b == cpm_pkg::TAG_END);
  wire logic       at_cmd   = rx_fall & frame_ok_ff &
                              (cur_b == cpm_pkg::SLOT1_END);
  wire logic       at_dat   = rx_fall & frame_ok_ff &
                              (cur_b == cpm_pkg::SLOT2_END);
  wire logic       at_last  = rx_fall & (cur_b == cpm_pkg::LAST_BIT);
  wire logic       wr_go    = at_dat & (&tag_ff) & ~rw_ff;
  wire logic       rd_go    = at_dat & tag_ff[2] & tag_ff[1] & rw_ff;
  wire logic [15:0] wr_data = sh_nxt[19:4];
  wire logic       wr_std   = wr_go & (addr_ff == cpm_pkg::ADDR_STD_PD);

  // 13 slots in 256 bits per frame, counted from the sync rise
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff       <= 8'h00;
      frame_ok_ff  <= 1'b0;
      sync_prev_ff <= 1'b0;
      shift_ff     <= 20'h00000;
    end
    else if (!link_up)
    begin
      frame_ok_ff  <= 1'b0;
      sync_prev_ff <= 1'b0;
    end
    else if (rx_fall)
    begin
      sync_prev_ff <= s_sync;
      cnt_ff       <= cur_b;  // see [RL23]
      shift_ff     <= sh_nxt;
      if (sync_up)
      begin
        frame_ok_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_ff  <= 3'h0;
      rw_ff   <= 1'b0;
      addr_ff <= 7'h00;
    end
    else
    begin
      if (at_tag)
      begin
        tag_ff <= sh_nxt[2:0];
      end
      if (at_cmd)
      begin
        rw_ff   <= sh_nxt[19];
        addr_ff <= sh_nxt[18:12];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  function automatic logic [15:0] rd_data(input logic [6:0] a,
                                          input logic [15:0] sp,
                                          input logic [15:0] ep,
                                          input logic [15:0] af,
                                          input logic [15:0] bs,
                                          input logic [15:0] bp,
                                          input logic [15:0] mc,
                                          input logic [15:0] rc);
    case (a)
      cpm_pkg::ADDR_STD_PD: rd_data = {sp[15:4],
                                       ~sp[cpm_pkg::STD_MIX_OFF],
                                       ~sp[cpm_pkg::STD_REF_MIX],
                                       ~sp[cpm_pkg::STD_DAC_OFF],
                                       ~sp[cpm_pkg::STD_ADC_OFF]};
      cpm_pkg::ADDR_EXT_PD: rd_data = ep;
      cpm_pkg::ADDR_AFC:    rd_data = af;
      cpm_pkg::ADDR_BIAS:   rd_data = bs;
      cpm_pkg::ADDR_BEEP:   rd_data = bp;
      cpm_pkg::ADDR_MIC:    rd_data = mc;
      cpm_pkg::ADDR_REC:    rd_data = rc;
      default:              rd_data = 16'h0000;
    endcase
  endfunction

  wire logic wake_go;

  // strap taken once, on the first clock after reset release
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_ff   <= 1'b0;
      std_pd_ff <= cpm_pkg::STD_PD_RST;
    end
    else if (!init_ff)
    begin
      init_ff   <= 1'b1;
      std_pd_ff <= s_strap ? cpm_pkg::STD_PD_STRAP  // see [RL1]
                           : cpm_pkg::STD_PD_RST;   // see [RL2]
    end
    else if (wr_std)
    begin
      std_pd_ff <= wr_data & cpm_pkg::STD_PD_MASK;  // see [RL9]
    end
    else if (wake_go)
    begin
      std_pd_ff[cpm_pkg::STD_LINK_OFF] <= 1'b0;  // see [RL11]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_pd_ff <= cpm_pkg::EXT_PD_RST;  // see [RL4]
      afc_ff    <= cpm_pkg::AFC_RST;     // see [RL13] see [RL15]
      bias_ff   <= cpm_pkg::BIAS_RST;    // see [RL16]
      beep_ff   <= cpm_pkg::BEEP_RST;
      mic_ff    <= cpm_pkg::MIC_RST;
      rec_ff    <= cpm_pkg::REC_RST;
    end
    else if (wr_go)
    begin
      case (addr_ff)
        cpm_pkg::ADDR_EXT_PD: ext_pd_ff <= wr_data;  // see [RL5] see [RL6]
        cpm_pkg::ADDR_AFC:    afc_ff  <= wr_data & cpm_pkg::AFC_MASK;
        cpm_pkg::ADDR_BIAS:   bias_ff <= wr_data & cpm_pkg::BIAS_MASK;
        cpm_pkg::ADDR_BEEP:   beep_ff <= wr_data;
        cpm_pkg::ADDR_MIC:    mic_ff  <= wr_data;
        cpm_pkg::ADDR_REC:    rec_ff  <= wr_data;
        default:              ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep and wake

  wire logic warm_rst = sync_lvl_ff & ~s_sync;
  wire logic irq_wake = s_wake & afc_ff[cpm_pkg::AFC_WAKE_EN];  // see [RL12]
  assign wake_go = (st_ff == cpm_pkg::ST_SLEEP) & (warm_rst | irq_wake);
  wire logic wake_done = wake_cnt_ff == 8'(cpm_pkg::WAKE_CYC - 1);

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      cpm_pkg::ST_ACTIVE:
        if (std_pd_ff[cpm_pkg::STD_LINK_OFF] && init_ff)
        begin
          nxt_st = cpm_pkg::ST_SLEEP;  // see [RL8]
        end
      cpm_pkg::ST_SLEEP:
        if (wake_go)
        begin
          nxt_st = cpm_pkg::ST_WAKE;  // see [RL11]
        end
      cpm_pkg::ST_WAKE:
        if (wake_done)
        begin
          nxt_st = cpm_pkg::ST_ACTIVE;
        end
      default: nxt_st = cpm_pkg::ST_ACTIVE;
    endcase
  end

  // bit clock held off for the startup delay after a wake
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff       <= cpm_pkg::ST_ACTIVE;
      wake_cnt_ff <= 8'h00;
      sync_lvl_ff <= 1'b0;
    end
    else
    begin
      st_ff       <= nxt_st;
      sync_lvl_ff <= s_sync;
      wake_cnt_ff <= (st_ff == cpm_pkg::ST_WAKE) ?
                     8'(wake_cnt_ff + 8'h01) : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer, sent in the frame after the request

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_pend_ff <= 1'b0;
      rsp_live_ff <= 1'b0;
      rsp_addr_ff <= 7'h00;
      rsp_data_ff <= 16'h0000;
    end
    else if (!link_up)
    begin
      rsp_pend_ff <= 1'b0;
      rsp_live_ff <= 1'b0;
    end
    else if (rd_go)
    begin
      rsp_pend_ff <= 1'b1;
      rsp_addr_ff <= addr_ff;
      rsp_data_ff <= rd_data(addr_ff, std_pd_ff, ext_pd_ff, afc_ff,
                             bias_ff, beep_ff, mic_ff, rec_ff);
    end
    else if (at_last)
    begin
      rsp_live_ff <= rsp_pend_ff;
      rsp_pend_ff <= 1'b0;
    end
  end

  function automatic logic tx_bit(input logic [7:0] b,
                                  input logic live,
                                  input logic [6:0] a,
                                  input logic [15:0] d);
    logic [19:0] w;
    logic [7:0]  i;
    w = 20'h00000;
    i = 8'h00;
    if (b <= cpm_pkg::SLOT0_END)
    begin
      w = {4'h0, 1'b1, live, live, 13'h0000};
      i = 8'(cpm_pkg::SLOT0_END - b);
    end
    else if (b <= cpm_pkg::SLOT1_END)
    begin
      w = live ? {1'b0, a, 12'h000} : 20'h00000;
      i = 8'(cpm_pkg::SLOT1_END - b);
    end
    else if (b <= cpm_pkg::SLOT2_END)
    begin
      w = live ? {d, 4'h0} : 20'h00000;
      i = 8'(cpm_pkg::SLOT2_END - b);
    end
    tx_bit = w[i[4:0]];
  endfunction

  // driven on the rising edge ahead of the bit the controller takes
  wire logic [7:0] tx_b  = 8'(cnt_ff + 8'h01);
  wire logic       tx_nx = tx_bit(tx_b, rsp_live_ff, rsp_addr_ff,
                                  rsp_data_ff);

  ////////////////////////////////////////////////////////////////////////
  // derived power conditions

  logic [15:0] en_w;
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_en
      assign en_w[g] = ~ext_pd_ff[g] &
                       ~std_pd_ff[cpm_pkg::std_of_ext(g)];  // see [RL3]
    end
  endgenerate

  wire logic all_off = (&ext_pd_ff) &
                       (&(std_pd_ff | ~cpm_pkg::STD_PD_MASK));
  wire logic [1:0] ms = mic_ff[cpm_pkg::MIC_SEL_LSB +: 2];
  wire logic rec_mic = (rec_ff[cpm_pkg::REC_L_LSB +: 3] ==
                        cpm_pkg::REC_SRC_MIC) |
                       (rec_ff[cpm_pkg::REC_R_LSB +: 3] ==
                        cpm_pkg::REC_SRC_MIC);
  wire logic mic_base = ext_pd_ff[cpm_pkg::EXT_MIC_PGA] &
                        std_pd_ff[cpm_pkg::STD_ADC_OFF] & rec_mic;
  wire logic b2h = beep_ff[cpm_pkg::BEEP_TO_HP];
  wire logic beep_off =
    std_pd_ff[cpm_pkg::STD_MIX_OFF] |  // see [RL20]
    ((ext_pd_ff[cpm_pkg::EXT_LHP_MIX] | b2h) &
     (ext_pd_ff[cpm_pkg::EXT_RHP_MIX] | b2h) &
     (ext_pd_ff[cpm_pkg::EXT_SPK_MIX] | beep_ff[cpm_pkg::BEEP_TO_SPK]) &
     (ext_pd_ff[cpm_pkg::EXT_MONO_BUF] | beep_ff[cpm_pkg::BEEP_TO_PH]));
  wire logic sleeping = (st_ff != cpm_pkg::ST_ACTIVE) |
                        std_pd_ff[cpm_pkg::STD_LINK_OFF];

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      block_en_out                 <= 16'h0000;
      sleep_out                    <= 1'b0;
      standby_out                  <= 1'b0;
      ref_string_on_out            <= 1'b0;
      unused_pins_held_out         <= 1'b0;
      bias_level_out               <= 2'h0;
      first_mic_input_ref_off_out  <= 1'b0;
      second_mic_input_ref_off_out <= 1'b0;
      beep_input_ref_off_out       <= 1'b0;
      battery_measure_en_out       <= 1'b0;
      bit_clk_oe_out               <= 1'b0;
      sdata_in_out                 <= 1'b0;
    end
    else
    begin
      block_en_out      <= init_ff ? en_w : 16'h0000;  // see [RL26]
      sleep_out         <= sleeping;  // see [RL8]
      standby_out       <= all_off;  // see [RL14]
      ref_string_on_out <= ~afc_ff[cpm_pkg::AFC_REF_DIS];  // see [RL15]
      unused_pins_held_out <=
        ~std_pd_ff[cpm_pkg::STD_REF_MIX];  // see [RL17]
      bias_level_out <= bias_ff[cpm_pkg::BIAS_LSB +: 2];  // see [RL16]
      first_mic_input_ref_off_out <=
        mic_base & (ms == cpm_pkg::MIC_SEL_FIRST);  // see [RL18]
      second_mic_input_ref_off_out <=
        mic_base & (ms == cpm_pkg::MIC_SEL_SECOND);  // see [RL19]
      beep_input_ref_off_out <= beep_off;  // see [RL21]
      battery_measure_en_out <= ~sleeping;  // see [RL10]
      bit_clk_oe_out <= run_clk & ~s_extsel;  // see [RL22]
      if (!link_up)
      begin
        sdata_in_out <= 1'b0;
      end
      else if (bclk_rise)
      begin
        sdata_in_out <= frame_ok_ff & tx_nx;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/cpm_pkg.sv
// package: constants for codec power management
// What this block does
// [RL1] strap high at reset starts every standard power-down block off
// [RL2] strap level affects only the standard power-down register reset value
// [RL3] a block runs only when its standard and extended bits are both zero
// [RL4] extended register resets all on; bits 15..10 oscillator, dacs, adcs, bias
// [RL5] extended bits 9..4 gate mixers, mono and phone, third and hp buffers
// [RL6] extended bits 3..0 gate speaker outputs and line, phone, mic gain
// [RL7] software mutes a gain stage before powering it down
// [RL8] link power-down bit set disables the link and means sleep
// [RL9] link power-down is standard register bit 12
// [RL10] in sleep clockless functions run on, battery measurement stops
// [RL11] a warm reset on the link wakes the device and restarts the link
// [RL12] an interrupt event wakes the device only when wake is enabled
// [RL13] wake enable is a bit of additional control, reset disabled
// [RL14] all power-down bits set means standby, string kept unless disabled
// [RL15] reference disable at bit 10 resets 0; 1 disconnects the string
// [RL16] bias field 6:5 resets 00; 11 lowest, 10 low, else default
// [RL17] disabled pins held at reference unless reference and mixers are off
// [RL18] first mic input released under mic, adc, select 00, record 000
// [RL19] second mic input released likewise with select field 10
// [RL20] beep input released when mixer power-down bit is set
// [RL21] beep input released when every mixer is off or beep-routed
// [RL22] bit clock made from own oscillator, or taken from outside
// [RL23] 13 slots, 256 bits a frame, 48 kHz frame rate
// [RL24] controller holds sync and data low through cold reset
// [RL25] controller drives sync at 48 kHz with a 1.3 us pulse
// [RL26] link writes reach the enable outputs one clock after the write
`default_nettype none
package cpm_pkg;
  localparam logic [6:0] ADDR_STD_PD = 7'h26;
  localparam logic [6:0] ADDR_EXT_PD = 7'h24;
  localparam logic [6:0] ADDR_AFC    = 7'h58;
  localparam logic [6:0] ADDR_BIAS   = 7'h5c;
  localparam logic [6:0] ADDR_BEEP   = 7'h0a;
  localparam logic [6:0] ADDR_MIC    = 7'h0e;
  localparam logic [6:0] ADDR_REC    = 7'h1a;
  localparam logic [15:0] STD_PD_RST   = 16'h0000;
  localparam logic [15:0] STD_PD_STRAP = 16'h7f00;
  localparam logic [15:0] STD_PD_MASK  = 16'h7f00;
  localparam logic [15:0] EXT_PD_RST   = 16'h0000;
  localparam logic [15:0] AFC_RST      = 16'h0000;
  localparam logic [15:0] AFC_MASK     = 16'h0403;
  localparam logic [15:0] BIAS_RST     = 16'h0000;
  localparam logic [15:0] BIAS_MASK    = 16'h0060;
  localparam logic [15:0] BEEP_RST     = 16'haaa0;
  localparam logic [15:0] MIC_RST      = 16'h6808;
  localparam logic [15:0] REC_RST      = 16'h3000;
  localparam int STD_HP_OFF   = 14;
  localparam int STD_CLK_OFF  = 13;
  localparam int STD_LINK_OFF = 12;
  localparam int STD_REF_MIX  = 11;
  localparam int STD_MIX_OFF  = 10;
  localparam int STD_DAC_OFF  = 9;
  localparam int STD_ADC_OFF  = 8;
  localparam int EXT_OSC_OFF  = 15;
  localparam int EXT_LHP_MIX  = 9;
  localparam int EXT_RHP_MIX  = 8;
  localparam int EXT_SPK_MIX  = 7;
  localparam int EXT_MONO_BUF = 6;
  localparam int EXT_MIC_PGA  = 0;
  localparam int AFC_WAKE_EN  = 1;
  localparam int AFC_REF_DIS  = 10;
  localparam int BIAS_LSB     = 5;
  localparam int BEEP_TO_HP   = 15;
  localparam int BEEP_TO_SPK  = 11;
  localparam int BEEP_TO_PH   = 7;
  localparam int MIC_SEL_LSB  = 5;
  localparam int REC_L_LSB    = 8;
  localparam int REC_R_LSB    = 0;
  localparam logic [1:0] MIC_SEL_FIRST  = 2'h0;
  localparam logic [1:0] MIC_SEL_SECOND = 2'h2;
  localparam logic [2:0] REC_SRC_MIC    = 3'h0;
  localparam int SLOT_COUNT = 13;
  localparam int FRAME_BITS = 256;
  localparam logic [7:0] LAST_BIT   = 8'hff;
  localparam logic [7:0] TAG_END    = 8'h02;
  localparam logic [7:0] SLOT0_END  = 8'h0f;
  localparam logic [7:0] SLOT1_END  = 8'h23;
  localparam logic [7:0] SLOT2_END  = 8'h37;
  localparam int SYS_CLK_KHZ  = 10000;
  localparam int WAKE_DLY_PS  = 162400;
  localparam int WAKE_CYC =
    (WAKE_DLY_PS / 1000 * SYS_CLK_KHZ + 999999) / 1000000 + 1;
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} cpm_link_e;
  // standard bit that also gates each extended bit
  function automatic int std_of_ext(input int i);
    case (i)
      15:      std_of_ext = STD_CLK_OFF;
      14, 13:  std_of_ext = STD_DAC_OFF;
      5, 4:    std_of_ext = STD_HP_OFF;
      9, 8, 7, 6, 3: std_of_ext = STD_MIX_OFF;
      default: std_of_ext = STD_ADC_OFF;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> rtl/cpm_sync.sv
// two flip-flop synchroniser for pin levels
`default_nettype none
module cpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] s1_ff;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("cpm_sync: width must be at least one");
    end
  end

  // no reset so a strap level is already settled at reset release
  always_ff @(posedge clk_sys_in)
  begin
    s1_ff <= d_in;
    q_out <= s1_ff;
  end
endmodule
`default_nettype wire

// >>> rtl/cpm_bitclk.sv
// bit clock divider and edge finder for the link
`default_nettype none
module cpm_bitclk #(
  parameter int HALF_DIV = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  input  wire logic ext_sel_in,
  input  wire logic ext_clk_in,
  output var  logic clk_out,
  output wire logic rise_out,
  output wire logic fall_out
);
  logic [7:0] div_ff;
  logic       lvl_ff;
  wire  logic lvl = ext_sel_in ? ext_clk_in : clk_out;

  initial
  begin
    if (HALF_DIV < 2 || HALF_DIV > 255)
    begin
      $error("cpm_bitclk: half divider out of range");
    end
  end

  assign rise_out = lvl & ~lvl_ff;
  assign fall_out = ~lvl & lvl_ff;

  // internal clock parks low while stopped
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_ff  <= 8'h00;
      clk_out <= 1'b0;
      lvl_ff  <= 1'b0;
    end
    else
    begin
      lvl_ff <= lvl;
      if (!run_in || ext_sel_in)
      begin
        div_ff  <= 8'h00;
        clk_out <= 1'b0;
      end
      else if (div_ff == 8'(HALF_DIV - 1))
      begin
        div_ff  <= 8'h00;
        clk_out <= ~clk_out;
      end
      else
      begin
        div_ff <= 8'(div_ff + 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/cpm_props.sv
// checker: power-management relations seen at the top ports
`default_nettype none
module cpm_props (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        powerup_strap_in,
  input wire logic        bit_clk_out,
  input wire logic        sdata_in_out,
  input wire logic [15:0] block_en_out,
  input wire logic        sleep_out,
  input wire logic        standby_out,
  input wire logic        unused_pins_held_out,
  input wire logic        beep_input_ref_off_out,
  input wire logic        first_mic_input_ref_off_out,
  input wire logic        second_mic_input_ref_off_out,
  input wire logic        battery_measure_en_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence asleep_s;
    sleep_out [*8];
  endsequence
  // internal release, strap capture and output flop fit in six edges
  property start_p(logic s, logic [15:0] e);
    $rose(rst_n_in) && powerup_strap_in == s |-> ##6 block_en_out == e
      && sleep_out == s;
  endproperty
  strap_on_a: assert property (start_p(1'b1, 16'h0000))
    else $error("strap start not all off");
  strap_off_a: assert property (start_p(1'b0, 16'hffff))
    else $error("plain start not all on");
  standby_off_a: assert property (standby_out |-> block_en_out == 0)
    else $error("block enabled in standby");
  standby_state_a: assert property (standby_out [*2] |-> sleep_out
    && !unused_pins_held_out && beep_input_ref_off_out)
    else $error("standby side conditions wrong");
  sleep_batt_a: assert property (asleep_s |-> !battery_measure_en_out)
    else $error("battery measurement on in sleep");
  sleep_quiet_a: assert property (asleep_s |-> ##2
    (!bit_clk_out && !sdata_in_out) || !sleep_out)
    else $error("link still active in sleep");
  mic_excl_a: assert property (!(first_mic_input_ref_off_out
    && second_mic_input_ref_off_out))
    else $error("both mic inputs released");
  mic_block_a: assert property (first_mic_input_ref_off_out [*2]
    |-> block_en_out[0] == 1'b0 && block_en_out[12] == 1'b0)
    else $error("mic released with its blocks on");
endmodule
bind cpm_top cpm_props cpm_props_inst (.*);
`default_nettype wire

// >>> tb/cpm_link_ctrl.sv
// partner: link controller sending one command frame at a time
`default_nettype none
module cpm_link_ctrl (
  input  wire logic        bclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        req_in,
  input  wire logic        warm_in,
  input  wire logic [6:0]  addr_in,
  input  wire logic [15:0] data_in,
  output wire logic        sync_out,
  output wire logic        sdo_out,
  output var  logic [7:0]  sent_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;
  logic       go_ff;
  wire logic  tag_bit = cnt_ff < 8'h03;
  wire logic  adr_bit = cnt_ff > 8'h10 && cnt_ff < 8'h18;
  wire logic  dat_bit = cnt_ff > 8'h23 && cnt_ff < 8'h34;
  // starting past slot 0 keeps sync low across the reset release
  assign sync_out = rst_n_in && (warm_in || cnt_ff < 8'h10);
  assign sdo_out = go_ff && (tag_bit || adr_bit && addr_in[8'h17 - cnt_ff]
    || dat_bit && data_in[8'h33 - cnt_ff]);
  always_ff @(posedge bclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff   <= 8'h10;
      go_ff    <= 1'b0;
      sent_out <= 8'h00;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
      if (cnt_ff == 8'hff)
        go_ff <= req_in;
      if (cnt_ff == 8'h33 && go_ff)
        sent_out <= sent_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// testbench: link writes, sleep, wake and strap start-up
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, powerup_strap_in = 1'b0;
  logic bit_clk_in = 1'b0, ext_clk_sel_in = 1'b1, wake_event_in = 1'b0;
  logic req = 1'b0, warm = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [15:0] data = 16'h0000;
  wire logic sync_in, sdata_out_in, bit_clk_out, bit_clk_oe_out;
  wire logic sdata_in_out, sleep_out, standby_out, ref_string_on_out;
  wire logic unused_pins_held_out, first_mic_input_ref_off_out;
  wire logic second_mic_input_ref_off_out, beep_input_ref_off_out;
  wire logic battery_measure_en_out;
  wire logic [15:0] block_en_out;
  wire logic [1:0]  bias_level_out;
  wire logic [7:0]  sent;
  int mismatches = 0, cmp_count = 0, cyc = 0, k;
  logic [41:0] rows [8] = '{{7'h24, 16'h8001, 16'h7ffe, 2'h0, 1'b1},
    {7'h5c, 16'h0060, 16'h7ffe, 2'h3, 1'b1},
    {7'h5c, 16'h0040, 16'h7ffe, 2'h2, 1'b1},
    {7'h5c, 16'h0020, 16'h7ffe, 2'h1, 1'b1},
    {7'h58, 16'h0400, 16'h7ffe, 2'h1, 1'b0},
    {7'h30, 16'hffff, 16'h7ffe, 2'h1, 1'b0},
    {7'h58, 16'h0000, 16'h7ffe, 2'h1, 1'b1},
    {7'h24, 16'h0000, 16'hffff, 2'h1, 1'b1}};
  cpm_top cpm_top_inst (.*);
  cpm_link_ctrl cpm_link_ctrl_inst (.bclk_in(bit_clk_in), .rst_n_in,
    .req_in(req), .warm_in(warm), .addr_in(addr), .data_in(data),
    .sync_out(sync_in), .sdo_out(sdata_out_in), .sent_out(sent));
  always #50 clk_sys_in = ~clk_sys_in;
  initial #130 forever #400 bit_clk_in = ~bit_clk_in;
  task automatic chk(input string n, input logic [19:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [7:0] n;
    n = sent;
    addr = a;
    data = d;
    req = 1'b1;
    for (k = 0; k < 7000 && sent === n; k++) @(negedge clk_sys_in);
    req = 1'b0;
    chk("frames sent", sent, n + 8'h01);
    repeat (60) @(negedge clk_sys_in);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i][41:35], rows[i][34:19]);
      chk("block enables", block_en_out, rows[i][18:3]);
      chk("bias level", bias_level_out, rows[i][2:1]);
      chk("string on", ref_string_on_out, rows[i][0]);
    end
    wr(7'h24, 16'hffff);
    wr(7'h26, 16'h7f00);
    chk("standby flags", {standby_out, sleep_out, unused_pins_held_out,
      battery_measure_en_out, beep_input_ref_off_out,
      first_mic_input_ref_off_out, second_mic_input_ref_off_out},
      7'h66);
    // wake enable still clear, so the event must be ignored
    wake_event_in = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    wake_event_in = 1'b0;
    chk("asleep", sleep_out, 1'b1);
    warm = 1'b1;
    repeat (13) @(negedge clk_sys_in);
    warm = 1'b0;
    for (k = 0; k < 100 && sleep_out !== 1'b0; k++) @(negedge clk_sys_in);
    chk("warm woken", {sleep_out, standby_out}, 2'h0);
    repeat (2100) @(negedge clk_sys_in);
    wr(7'h58, 16'h0002);
    wr(7'h26, 16'h1000);
    chk("link off", {sleep_out, block_en_out}, 17'h10000);
    wake_event_in = 1'b1;
    for (k = 0; k < 100 && sleep_out !== 1'b0; k++) @(negedge clk_sys_in);
    wake_event_in = 1'b0;
    chk("event woken", sleep_out, 1'b0);
    powerup_strap_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    chk("strap start", {block_en_out, sleep_out, bias_level_out,
      ref_string_on_out}, 20'h00009);
    print_verdict();
  end
endmodule
`default_nettype wire
